// >>> rtl/camera_video_port.v
// Camera video output port with paged register file behind a two-wire serial bus.
// Assumes pads resolve drive from the enables; rst is synchronous to clk, other pins except resetN are asynchronous.
`timescale 1ns/1ps
`include "camera_port_defines.vh"
module camera_video_port #(
	parameter ACT_WORDS   = 1280,
	parameter ACT_LINES   = 480,
	parameter LINE_TOTAL  = 1600,
	parameter FRAME_LINES = 500,
	parameter EXPO_MAX    = 16'h03ff,
	parameter EXTRA_STEP  = 16'h0020,
	parameter EXTRA_MAX   = 16'h01f4,
	parameter CHIP_ID     = 16'h5a01
) (
	// Clock and resets
	input  wire       clk,
	input  wire       rst,
	input  wire       resetN,
	// Control pins
	input  wire       standby,
	input  wire       outEnableN,
	input  wire       addrSelect,
	// Two-wire serial bus
	input  wire       sclIn,
	input  wire       sdaIn,
	output wire       sdaOut,
	output wire       sdaOe,
	// Video port
	output reg  [7:0] pixData,
	output reg        pixel_out_clock,
	output reg        lineValid,
	output reg        frameValid,
	output reg        videoOe
);
	// ****************************************
	// Frame rate figures
	// ****************************************
	localparam integer MAX_WORD_RATE_KHZ = `MCLK_MAX_KHZ;
	localparam integer DEF_FRAME_CLKS    = `MCLK_DEF_KHZ * 1000 / `FPS_DEF;
	localparam integer MAX_FRAME_CLKS    = `MCLK_MAX_KHZ * 1000 / `FPS_MAX;

	// ****************************************
	// Declarations
	// ****************************************
	reg  [4:0]  sync1_reg;
	reg  [4:0]  sync2_reg;
	reg         sdaOut_reg;
	reg         phase_reg;
	reg  [15:0] page_reg;
	reg  [15:0] expo_reg;
	reg  [15:0] outCtl_reg;
	reg  [15:0] aeCtl_reg;
	reg  [15:0] target_reg;
	reg  [15:0] frameCnt_reg;
	reg  [15:0] extra_reg;
	reg  [23:0] balance_reg;
	reg  [15:0] rdData;
	wire        sclSync;
	wire        sdaSync;
	wire        sleepSync;
	wire        oeNSync;
	wire        addrSelSync;
	wire [6:0]  devAddr;
	wire [7:0]  regAddr;
	wire        wrStb;
	wire [15:0] wrData;
	wire        slaveOe;
	wire        running;
	wire        tick;
	wire [15:0] wordCol;
	wire [15:0] row;
	wire        lineAct;
	wire        frameAct;
	wire        frameDone;
	wire [7:0]  luma;
	wire        onSensor;
	wire        onPipe;
	wire        hostExpoWr;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always @(posedge clk or negedge resetN) begin
		if (!resetN) begin
			sync1_reg <= 5'h1b;
			sync2_reg <= 5'h1b;
		end else begin
			sync1_reg <= {addrSelect, outEnableN, standby, sdaIn, sclIn};
			sync2_reg <= sync1_reg;
		end
	end

	assign sclSync     = sync2_reg[0];
	assign sdaSync     = sync2_reg[1];
	assign sleepSync   = sync2_reg[2];
	assign oeNSync     = sync2_reg[3];
	assign addrSelSync = sync2_reg[4];
	assign devAddr     = addrSelSync ? `SADDR_HIGH : `SADDR_LOW;

	// ****************************************
	// Serial slave
	// ****************************************
	two_wire_slave slave (
		.clk     (clk),
		.rst     (rst),
		.resetN  (resetN),
		.scl     (sclSync),
		.sda     (sdaSync),
		.sdaOe   (slaveOe),
		.devAddr (devAddr),
		.rdData  (rdData),
		.regAddr (regAddr),
		.wrStb   (wrStb),
		.wrData  (wrData)
	);

	// Open drain: the pad only ever pulls low
	always @(posedge clk or negedge resetN) begin
		if (!resetN) begin
			sdaOut_reg <= 1'b0;
		end else begin
			sdaOut_reg <= 1'b0;
		end
	end

	assign sdaOut = sdaOut_reg;
	assign sdaOe  = slaveOe;

	// ****************************************
	// Page decode
	// ****************************************
	assign onSensor   = (page_reg == `PAGE_SENSOR);
	assign onPipe     = (page_reg == `PAGE_PIPE);
	assign hostExpoWr = wrStb && onSensor && (regAddr == `REG_SNS_EXPO);

	// Read mux follows the page in force now, so a finished page write counts at once
	always @* begin
		rdData = 16'h0000;
		if (regAddr == `REG_PAGE) begin
			rdData = page_reg;
		end else if (regAddr == `REG_CHIP_ID) begin
			rdData = CHIP_ID;
		end else if (onSensor) begin
			if (regAddr == `REG_SNS_EXPO) begin
				rdData = expo_reg;
			end
		end else if (onPipe) begin
			case (regAddr)
				`REG_PIPE_OUTCTL: rdData = outCtl_reg;
				`REG_PIPE_AECTL:  rdData = aeCtl_reg;
				`REG_PIPE_TARGET: rdData = target_reg;
				`REG_PIPE_STATUS: rdData = frameCnt_reg;
				default:          rdData = 16'h0000;
			endcase
		end
	end

	// ****************************************
	// Register file and auto exposure
	// ****************************************
	always @(posedge clk or negedge resetN) begin
		if (!resetN) begin
			page_reg     <= `PAGE_RST;
			expo_reg     <= `EXPO_RST;
			outCtl_reg   <= `OUTCTL_RST;
			aeCtl_reg    <= `AECTL_RST;
			target_reg   <= `TARGET_RST;
			frameCnt_reg <= 16'h0000;
			extra_reg    <= 16'h0000;
			balance_reg  <= 24'h000000;
		end else if (rst) begin
			page_reg     <= `PAGE_RST;
			expo_reg     <= `EXPO_RST;
			outCtl_reg   <= `OUTCTL_RST;
			aeCtl_reg    <= `AECTL_RST;
			target_reg   <= `TARGET_RST;
			frameCnt_reg <= 16'h0000;
			extra_reg    <= 16'h0000;
			balance_reg  <= 24'h000000;
		end else begin
			if (wrStb && regAddr == `REG_PAGE) begin
				page_reg <= wrData;
			end
			if (wrStb && onPipe) begin
				case (regAddr)
					`REG_PIPE_OUTCTL: outCtl_reg <= wrData;
					`REG_PIPE_AECTL:  aeCtl_reg  <= wrData;
					`REG_PIPE_TARGET: target_reg <= wrData;
					default:          outCtl_reg <= outCtl_reg;
				endcase
			end
			// Brightness balance: above target counts up, below counts down
			if (tick && lineAct && wordCol[0]) begin
				if (luma > target_reg[7:0]) begin
					balance_reg <= balance_reg + 24'h000001;
				end else if (luma < target_reg[7:0]) begin
					balance_reg <= balance_reg - 24'h000001;
				end
			end
			// Host write wins over the once-per-frame automatic step
			if (hostExpoWr) begin
				expo_reg <= wrData;
			end else if (frameDone && aeCtl_reg[`AE_EN_BIT]) begin
				if (!balance_reg[23] && balance_reg != 24'h000000 && expo_reg > 16'h0001) begin
					expo_reg <= expo_reg - 16'h0001;
				end else if (balance_reg[23] && expo_reg < EXPO_MAX) begin
					expo_reg <= expo_reg + 16'h0001;
				end
			end
			if (frameDone) begin
				balance_reg  <= 24'h000000;
				frameCnt_reg <= frameCnt_reg + 16'h0001;
				// Long exposure at the limit needs a longer frame
				if (aeCtl_reg[`AFR_EN_BIT] && expo_reg >= EXPO_MAX && extra_reg < EXTRA_MAX) begin
					extra_reg <= extra_reg + EXTRA_STEP;
				end else if (expo_reg < (EXPO_MAX >> 1) && extra_reg >= EXTRA_STEP) begin
					extra_reg <= extra_reg - EXTRA_STEP;
				end
			end
		end
	end

	// ****************************************
	// Raster timing
	// ****************************************
	assign running = !sleepSync;
	assign tick    = running && phase_reg;

	video_timing #(
		.ACT_WORDS   (ACT_WORDS),
		.ACT_LINES   (ACT_LINES),
		.LINE_TOTAL  (LINE_TOTAL),
		.FRAME_LINES (FRAME_LINES)
	) timing (
		.clk        (clk),
		.rst        (rst),
		.resetN     (resetN),
		.tick       (tick),
		.run        (running),
		.extraLines (extra_reg),
		.wordCol    (wordCol),
		.row        (row),
		.lineAct    (lineAct),
		.frameAct   (frameAct),
		.frameDone  (frameDone)
	);

	// ****************************************
	// Formatter
	// ****************************************
	// Synthetic scene scaled by exposure, saturating at full scale
	function [7:0] scaleLuma;
		input [7:0]  base;
		input [15:0] expo;
		reg   [23:0] prod;
		begin
			prod = base * expo;
			scaleLuma = (prod[23:14] != 10'h000) ? 8'hff : prod[13:6];
		end
	endfunction

	function [7:0] formatWord;
		input [2:0] fmt;
		input [1:0] pos;
		input [7:0] y;
		reg   [7:0] b;
		begin
			b = ~y;
			case (fmt)
				`FMT_YCBCR:  formatWord = pos[0] ? y : (pos[1] ? {1'b1, y[7:1]} : 8'h80);
				`FMT_YUV:    formatWord = pos[0] ? y : (pos[1] ? {1'b0, y[7:1]} : 8'h00);
				`FMT_RGB565: formatWord = pos[0] ? {y[4:2], b[7:3]} : {y[7:3], y[7:5]};
				`FMT_RGB555: formatWord = pos[0] ? {y[5:3], b[7:3]} : {1'b0, y[7:3], y[7:6]};
				`FMT_RGB444: formatWord = pos[0] ? {y[7:4], b[7:4]} : {4'h0, y[7:4]};
				default:     formatWord = y;
			endcase
		end
	endfunction

	assign luma = scaleLuma(wordCol[8:1] + row[7:0], expo_reg);

	// ****************************************
	// Output pads
	// ****************************************
	// Data moves as the non-inverted clock falls, so it is steady at the rise
	always @(posedge clk or negedge resetN) begin
		if (!resetN) begin
			phase_reg       <= 1'b0;
			pixel_out_clock <= 1'b0;
			pixData         <= 8'h00;
			lineValid       <= 1'b0;
			frameValid      <= 1'b0;
			videoOe         <= 1'b0;
		end else if (rst) begin
			phase_reg       <= 1'b0;
			pixel_out_clock <= 1'b0;
			pixData         <= 8'h00;
			lineValid       <= 1'b0;
			frameValid      <= 1'b0;
			videoOe         <= 1'b0;
		end else begin
			videoOe <= !oeNSync;
			if (!running) begin
				// Clock parked and qualifiers low while asleep
				phase_reg       <= 1'b0;
				pixel_out_clock <= outCtl_reg[`PCLK_INV_BIT];
				lineValid       <= 1'b0;
				frameValid      <= 1'b0;
				pixData         <= 8'h00;
			end else begin
				phase_reg       <= !phase_reg;
				pixel_out_clock <= !phase_reg ^ outCtl_reg[`PCLK_INV_BIT];
				if (tick) begin
					pixData    <= lineAct ? formatWord(outCtl_reg[2:0], wordCol[1:0], luma) : 8'h00;
					lineValid  <= lineAct;
					frameValid <= frameAct;
				end
			end
		end
	end
endmodule

// >>> shared/camera_port_defines.vh
// Constants for the camera video port and register page logic.
// Assumes one 40 MHz core clock and a host that drives the serial bus slowly.
`ifndef CAMERA_PORT_DEFINES_VH
`define CAMERA_PORT_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define REG_CHIP_ID      8'h00
`define REG_PAGE         8'h01
`define REG_SNS_EXPO     8'h09
`define REG_PIPE_AECTL   8'h06
`define REG_PIPE_OUTCTL  8'h08
`define REG_PIPE_STATUS  8'h0f
`define REG_PIPE_TARGET  8'h2e

// ****************************************
// Page codes and reset values
// ****************************************
`define PAGE_SENSOR      16'h0004
`define PAGE_PIPE        16'h0001
`define PAGE_RST         16'h0004
`define EXPO_RST         16'h01f4
`define OUTCTL_RST       16'h0000
`define AECTL_RST        16'h0003
`define TARGET_RST       16'h0080

// ****************************************
// Field positions and encodings
// ****************************************
`define PCLK_INV_BIT     9
`define AE_EN_BIT        0
`define AFR_EN_BIT       1
`define FMT_YCBCR        3'h0
`define FMT_YUV          3'h1
`define FMT_RGB565       3'h2
`define FMT_RGB555       3'h3
`define FMT_RGB444       3'h4

// ****************************************
// Serial addresses (7-bit form of 0xB8 / 0x90)
// ****************************************
`define SADDR_HIGH       7'h5c
`define SADDR_LOW        7'h48

// ****************************************
// Timing figures
// ****************************************
`define MCLK_MAX_KHZ     27000
`define FPS_MAX          30
`define MCLK_DEF_KHZ     12000
`define FPS_DEF          15
`define CLK_KHZ          40000

`endif

// >>> rtl/video_timing.v
// Raster counters for the video port: word and line position plus qualifiers.
// Assumes tick is a one-cycle pulse, one per pixel clock period.
`timescale 1ns/1ps
module video_timing #(
	parameter ACT_WORDS   = 1280,
	parameter ACT_LINES   = 480,
	parameter LINE_TOTAL  = 1600,
	parameter FRAME_LINES = 500
) (
	// Clock and resets
	input  wire        clk,
	input  wire        rst,
	input  wire        resetN,
	// Control
	input  wire        tick,
	input  wire        run,
	input  wire [15:0] extraLines,
	// Position and qualifiers
	output wire [15:0] wordCol,
	output wire [15:0] row,
	output wire        lineAct,
	output wire        frameAct,
	output wire        frameDone
);
	reg  [15:0] hCnt_reg;
	reg  [15:0] vCnt_reg;
	wire        lineEnd;
	wire [15:0] lastLine;

	assign lastLine  = FRAME_LINES[15:0] + extraLines - 16'h0001;
	assign lineEnd   = tick && (hCnt_reg == LINE_TOTAL[15:0] - 16'h0001);
	assign frameDone = lineEnd && (vCnt_reg >= lastLine);
	assign wordCol   = hCnt_reg;
	assign row       = vCnt_reg;
	assign frameAct  = run && (vCnt_reg < ACT_LINES[15:0]);
	assign lineAct   = frameAct && (hCnt_reg < ACT_WORDS[15:0]);

	// Extra blank lines stretch the frame, lowering the frame rate
	always @(posedge clk or negedge resetN) begin
		if (!resetN) begin
			hCnt_reg <= 16'h0000;
			vCnt_reg <= 16'h0000;
		end else if (rst || !run) begin
			hCnt_reg <= 16'h0000;
			vCnt_reg <= 16'h0000;
		end else if (frameDone) begin
			hCnt_reg <= 16'h0000;
			vCnt_reg <= 16'h0000;
		end else if (lineEnd) begin
			hCnt_reg <= 16'h0000;
			vCnt_reg <= vCnt_reg + 16'h0001;
		end else if (tick) begin
			hCnt_reg <= hCnt_reg + 16'h0001;
		end
	end
endmodule

// >>> rtl/two_wire_slave.v
// Two-wire serial slave with 8-bit register index and 16-bit data, high byte first.
// Assumes scl and sda are already synchronised to clk; sda is open drain.
`timescale 1ns/1ps
module two_wire_slave (
	// Clock and resets
	input  wire        clk,
	input  wire        rst,
	input  wire        resetN,
	// Bus lines, synchronised
	input  wire        scl,
	input  wire        sda,
	output reg         sdaOe,
	// Register side
	input  wire [6:0]  devAddr,
	input  wire [15:0] rdData,
	output reg  [7:0]  regAddr,
	output reg         wrStb,
	output reg  [15:0] wrData
);
	localparam ST_IDLE = 5'h01;
	localparam ST_DEV  = 5'h02;
	localparam ST_REG  = 5'h04;
	localparam ST_WR   = 5'h08;
	localparam ST_RD   = 5'h10;

	reg  [4:0] state_reg;
	reg  [3:0] bitCnt_reg;
	reg  [7:0] shift_reg;
	reg  [7:0] rdShift_reg;
	reg  [7:0] dataHi_reg;
	reg        ackPh_reg;
	reg        byteHi_reg;
	reg        nack_reg;
	reg        sclPrev_reg;
	reg        sdaPrev_reg;
	wire       sclRise;
	wire       sclFall;
	wire       startCond;
	wire       stopCond;
	wire [7:0] sendByte;

	assign sclRise   = scl && !sclPrev_reg;
	assign sclFall   = !scl && sclPrev_reg;
	assign startCond = scl && sclPrev_reg && sdaPrev_reg && !sda;
	assign stopCond  = scl && sclPrev_reg && !sdaPrev_reg && sda;
	assign sendByte  = byteHi_reg ? rdData[15:8] : rdData[7:0];

	always @(posedge clk or negedge resetN) begin
		if (!resetN) begin
			state_reg   <= ST_IDLE;
			bitCnt_reg  <= 4'h0;
			shift_reg   <= 8'h00;
			rdShift_reg <= 8'h00;
			dataHi_reg  <= 8'h00;
			ackPh_reg   <= 1'b0;
			byteHi_reg  <= 1'b1;
			nack_reg    <= 1'b0;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			sdaOe       <= 1'b0;
			regAddr     <= 8'h00;
			wrStb       <= 1'b0;
			wrData      <= 16'h0000;
		end else if (rst) begin
			state_reg   <= ST_IDLE;
			bitCnt_reg  <= 4'h0;
			ackPh_reg   <= 1'b0;
			byteHi_reg  <= 1'b1;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			sdaOe       <= 1'b0;
			regAddr     <= 8'h00;
			wrStb       <= 1'b0;
		end else begin
			sclPrev_reg <= scl;
			sdaPrev_reg <= sda;
			wrStb       <= 1'b0;
			// Index steps a cycle after the strobe, so the word lands at the old index
			if (wrStb) begin
				regAddr <= regAddr + 8'h01;
			end
			if (startCond) begin
				state_reg  <= ST_DEV;
				bitCnt_reg <= 4'h0;
				ackPh_reg  <= 1'b0;
				sdaOe      <= 1'b0;
			end else if (stopCond) begin
				state_reg <= ST_IDLE;
				sdaOe     <= 1'b0;
			end else if (sclRise && state_reg != ST_IDLE) begin
				if (ackPh_reg) begin
					nack_reg <= sda;
				end else begin
					shift_reg  <= {shift_reg[6:0], sda};
					bitCnt_reg <= bitCnt_reg + 4'h1;
				end
			end else if (sclFall && state_reg != ST_IDLE) begin
				if (ackPh_reg) begin
					ackPh_reg  <= 1'b0;
					bitCnt_reg <= 4'h0;
					if (state_reg == ST_RD) begin
						if (nack_reg) begin
							state_reg <= ST_IDLE;
							sdaOe     <= 1'b0;
						end else begin
							sdaOe       <= !sendByte[7];
							rdShift_reg <= {sendByte[6:0], 1'b0};
						end
					end else begin
						sdaOe <= 1'b0;
					end
				end else if (bitCnt_reg == 4'h8) begin
					ackPh_reg <= 1'b1;
					case (state_reg)
						ST_DEV: begin
							if (shift_reg[7:1] == devAddr) begin
								sdaOe      <= 1'b1;
								nack_reg   <= 1'b0;
								byteHi_reg <= 1'b1;
								state_reg  <= shift_reg[0] ? ST_RD : ST_REG;
							end else begin
								state_reg <= ST_IDLE;
							end
						end
						ST_REG: begin
							sdaOe      <= 1'b1;
							regAddr    <= shift_reg;
							byteHi_reg <= 1'b1;
							state_reg  <= ST_WR;
						end
						ST_WR: begin
							sdaOe      <= 1'b1;
							byteHi_reg <= !byteHi_reg;
							if (byteHi_reg) begin
								dataHi_reg <= shift_reg;
							end else begin
								wrStb   <= 1'b1;
								wrData  <= {dataHi_reg, shift_reg};
							end
						end
						ST_RD: begin
							sdaOe      <= 1'b0;
							byteHi_reg <= !byteHi_reg;
							if (!byteHi_reg) begin
								regAddr <= regAddr + 8'h01;
							end
						end
						default: begin
							state_reg <= ST_IDLE;
						end
					endcase
				end else if (state_reg == ST_RD) begin
					sdaOe       <= !rdShift_reg[7];
					rdShift_reg <= {rdShift_reg[6:0], 1'b0};
				end
			end
		end
	end
endmodule

// >>> bench/camera_video_port_checker.sv
// Checker for the video port and serial pin behaviour.
// Assumes it is bound to camera_video_port and sees only its ports.
`timescale 1ns/1ps
module camera_video_port_checker #(
	parameter ACT_WORDS = 1280
) (
	// Clock and resets
	input wire       clk,
	input wire       rst,
	input wire       resetN,
	// Pins
	input wire       standby,
	input wire       outEnableN,
	input wire       sclIn,
	input wire       sdaOut,
	input wire       sdaOe,
	input wire [7:0] pixData,
	input wire       pixel_out_clock,
	input wire       lineValid,
	input wire       frameValid,
	input wire       videoOe
);
	// ****************************************
	// Helper logic and assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst || !resetN);
	reg [15:0] runLen_reg;
	// Cleared in standby: a cut line is not a short line
	always @(posedge clk) begin
		if (rst || !resetN || standby || !lineValid)
			runLen_reg <= 16'h0000;
		else
			runLen_reg <= runLen_reg + 16'h0001;
	end
	a_sda_open_drain: assert property (sdaOut == 1'b0) else $error("sda driven high");
	a_sda_edge_low: assert property ($changed(sdaOe) |-> !sclIn) else $error("sda moved with scl high");
	a_pads_off: assert property (outEnableN [*3] |=> !videoOe) else $error("pads driven while off");
	// After an async reset the synchroniser restarts from pads off
	a_pads_on: assert property ((resetN && !outEnableN) [*3] |=> videoOe) else $error("pads not driven");
	a_word_at_rise: assert property ($rose(pixel_out_clock) |-> $stable(pixData)) else $error("word moved at rise");
	a_line_in_frame: assert property (lineValid |-> frameValid) else $error("line outside frame");
	a_line_words: assert property ($fell(lineValid) && !standby |-> runLen_reg == 2 * ACT_WORDS)
		else $error("line length wrong");
	a_sleep_quiet: assert property (standby [*4] |-> !lineValid && !frameValid && pixData == 8'h00)
		else $error("video during sleep");
	cover property ($rose(frameValid));
	cover property ($rose(sdaOe));
	cover property (standby && !frameValid);
endmodule

bind camera_video_port camera_video_port_checker #(.ACT_WORDS(ACT_WORDS)) chk (
	.clk(clk), .rst(rst), .resetN(resetN), .standby(standby), .outEnableN(outEnableN),
	.sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .pixData(pixData), .pixel_out_clock(pixel_out_clock),
	.lineValid(lineValid), .frameValid(frameValid), .videoOe(videoOe));

// >>> bench/video_host_model.sv
// Host receiver model: counts words per line and lines per frame.
// Assumes a non-inverted pixel clock from the port.
`timescale 1ns/1ps
module video_host_model (
	// Video in
	input  wire        pclk,
	input  wire        lineValid,
	input  wire        frameValid,
	// Counts seen
	output reg  [15:0] wordsSeen,
	output reg  [15:0] linesSeen
);
	reg [15:0] w;
	reg [15:0] l;
	reg        lvPrev;
	initial begin
		w = 16'h0000;
		l = 16'h0000;
		lvPrev = 1'b0;
		wordsSeen = 16'h0000;
		linesSeen = 16'h0000;
	end
	// Sampled only on the pixel clock rise
	always @(posedge pclk) begin
		if (lineValid)
			w = w + 16'h0001;
		if (lvPrev && !lineValid) begin
			wordsSeen = w;
			w = 16'h0000;
			l = l + 16'h0001;
		end
		if (!frameValid && l != 16'h0000) begin
			linesSeen = l;
			l = 16'h0000;
		end
		lvPrev = lineValid;
	end
endmodule

// >>> bench/tb_camera_video_port.sv
// Testbench: serial register access, video framing, enable, sleep, reset.
// Assumes small raster parameters; sda has a pull-up modelled here.
`timescale 1ns/1ps
`include "camera_port_defines.vh"
module tb_camera_video_port;
	localparam ID = 16'h1234; // Arbitrary id value
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         resetN = 1'b1;
	reg         standby = 1'b0;
	reg         outEnableN = 1'b0;
	reg         addrSelect = 1'b1;
	reg         sclIn = 1'b1;
	reg         sdaIn = 1'b1;
	reg         mLow = 1'b0;
	reg  [6:0]  dev = 7'h5c;
	reg  [15:0] rv;
	wire        sdaOut, sdaOe, pclk, lineValid, frameValid, videoOe;
	wire [7:0]  pixData;
	wire [15:0] wordsSeen, linesSeen;
	integer     mismatches = 0;
	integer     compares = 0;
	integer     cycles = 0;
	integer     i;
	camera_video_port #(.ACT_WORDS(8), .ACT_LINES(4), .LINE_TOTAL(12), .FRAME_LINES(6),
		.CHIP_ID(ID)) dut (.clk(clk), .rst(rst), .resetN(resetN),
		.standby(standby), .outEnableN(outEnableN), .addrSelect(addrSelect), .sclIn(sclIn), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .pixData(pixData), .pixel_out_clock(pclk), .lineValid(lineValid),
		.frameValid(frameValid), .videoOe(videoOe));
	video_host_model host (.pclk(pclk), .lineValid(lineValid), .frameValid(frameValid),
		.wordsSeen(wordsSeen), .linesSeen(linesSeen));
	always #12.5 clk = ~clk;
	// Pull-up: line is low only while someone drives it
	always @(posedge clk) sdaIn <= !(mLow || sdaOe);
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			mismatches = mismatches + 1;
			final_report;
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task check(input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("compares=%0d mismatches=%0d", compares, mismatches);
			if (mismatches == 0 && compares > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// Eight clocks per step; a bit holds scl low two steps and high one, well within the fastest edge the slave keeps up with
	task half;
		repeat (8) @(posedge clk);
	endtask
	task sbit(input b);
		begin
			half;
			mLow <= !b;
			half;
			sclIn <= 1'b1;
			half;
			sclIn <= 1'b0;
		end
	endtask
	task rbit(output b);
		begin
			half;
			mLow <= 1'b0;
			half;
			sclIn <= 1'b1;
			half;
			b = sdaIn;
			sclIn <= 1'b0;
		end
	endtask
	task start;
		begin
			half;
			mLow <= 1'b0;
			half;
			sclIn <= 1'b1;
			half;
			mLow <= 1'b1;
			half;
			sclIn <= 1'b0;
		end
	endtask
	task stop;
		begin
			half;
			mLow <= 1'b1;
			half;
			sclIn <= 1'b1;
			half;
			mLow <= 1'b0;
			half;
		end
	endtask
	task sbyte(input [7:0] d, input ack);
		integer k;
		reg     b;
		begin
			for (k = 7; k >= 0; k = k - 1)
				sbit(d[k]);
			rbit(b);
			check({15'h0000, b}, {15'h0000, !ack});
		end
	endtask
	task rbyte(output [7:0] d, input last);
		integer k;
		begin
			for (k = 7; k >= 0; k = k - 1)
				rbit(d[k]);
			sbit(last);
		end
	endtask
	task wr(input [7:0] idx, input [15:0] v);
		begin
			start;
			sbyte({dev, 1'b0}, 1'b1);
			sbyte(idx, 1'b1);
			sbyte(v[15:8], 1'b1);
			sbyte(v[7:0], 1'b1);
			stop;
		end
	endtask
	task rd(input [7:0] idx, output [15:0] v);
		begin
			start;
			sbyte({dev, 1'b0}, 1'b1);
			sbyte(idx, 1'b1);
			start;
			sbyte({dev, 1'b1}, 1'b1);
			rbyte(v[15:8], 1'b0);
			rbyte(v[7:0], 1'b1);
			stop;
		end
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		rd(`REG_PAGE, rv); check(rv, `PAGE_RST);
		rd(`REG_CHIP_ID, rv); check(rv, ID);
		wr(`REG_PAGE, `PAGE_PIPE);
		rd(`REG_PAGE, rv); check(rv, `PAGE_PIPE);
		rd(`REG_PIPE_TARGET, rv); check(rv, `TARGET_RST);
		for (i = 0; i < 5; i = i + 1) begin
			wr(`REG_PIPE_OUTCTL, i[15:0]);
			rd(`REG_PIPE_OUTCTL, rv); check(rv, i[15:0]);
		end
		wr(`REG_PAGE, `PAGE_SENSOR);
		rd(`REG_PIPE_TARGET, rv); check(rv, 16'h0000);
		addrSelect <= 1'b0;
		start;
		sbyte({7'h5c, 1'b0}, 1'b0);
		stop;
		dev = 7'h48;
		rd(`REG_PAGE, rv); check(rv, `PAGE_SENSOR);
		@(negedge frameValid);
		@(negedge frameValid);
		check(wordsSeen, 16'h0008);
		check(linesSeen, 16'h0004);
		@(posedge clk) outEnableN <= 1'b1;
		repeat (4) @(posedge clk);
		check({15'h0000, videoOe}, 16'h0000);
		outEnableN <= 1'b0;
		repeat (4) @(posedge clk);
		check({15'h0000, videoOe}, 16'h0001);
		standby <= 1'b1;
		repeat (60) @(posedge clk);
		check({6'h00, lineValid, frameValid, pixData}, 16'h0000);
		// Invert bit tried while asleep, where the clock sits at its idle level
		wr(`REG_PAGE, `PAGE_PIPE);
		wr(`REG_PIPE_OUTCTL, 16'h0200);
		check({15'h0000, pclk}, 16'h0001);
		wr(`REG_PIPE_OUTCTL, 16'h0000);
		check({15'h0000, pclk}, 16'h0000);
		standby <= 1'b0;
		@(posedge clk) resetN <= 1'b0;
		@(posedge clk) resetN <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`REG_PAGE, rv); check(rv, `PAGE_RST);
		final_report;
	end
endmodule
